/* sio_clamp_min.sv */
`timescale 1ns/1ps
module sio_clamp_min (
  input wire logic sel,
  input wire logic [15:0] param_lim,
  input wire logic [15:0] cmd_lim,
  input wire logic [15:0] drv_lim,
  output logic [15:0] lim
);

  // The smallest of the three limits wins; with no select the torque is free.
  always_comb begin
    if (sel) begin
      lim = sio_pkg::sio_min2(sio_pkg::sio_min2(param_lim, cmd_lim), drv_lim);
    end else begin
      lim = sio_pkg::TORQ_NO_CLAMP;
    end
  end

endmodule // sio_clamp_min

/* sio_in_pack.sv */
`timescale 1ns/1ps
module sio_in_pack (
  input wire logic homing_decel_switch,
  input wire logic fwd_hw_overtravel,
  input wire logic rev_hw_overtravel,
  input wire logic emergency_stop_flag,
  input wire logic holding_brake_applied,
  input wire logic fwd_sw_overtravel,
  input wire logic rev_sw_overtravel,
  input wire logic profile_output_done,
  input wire logic close_to_target,
  input wire logic position_settled,
  input wire logic home_position_flag,
  input wire logic torque_limited_flag,
  input wire logic speed_limited_flag,
  input wire logic speed_match_flag,
  input wire logic [7:0] general_inputs,
  output logic [31:0] field
);

  // Unsupported latch inputs and reserved positions stay zero.
  always_comb begin
    field = 32'h00000000;
    field[sio_pkg::IN_DECEL_BIT] = homing_decel_switch;
    field[sio_pkg::IN_FWD_OT_BIT] = fwd_hw_overtravel;
    field[sio_pkg::IN_REV_OT_BIT] = rev_hw_overtravel;
    field[sio_pkg::IN_ESTOP_BIT] = emergency_stop_flag;
    field[sio_pkg::IN_BRAKE_BIT] = holding_brake_applied;
    field[sio_pkg::IN_FWD_SOT_BIT] = fwd_sw_overtravel;
    field[sio_pkg::IN_REV_SOT_BIT] = rev_sw_overtravel;
    field[sio_pkg::IN_PROFILE_DONE_BIT] = profile_output_done;
    field[sio_pkg::IN_CLOSE_BIT] = close_to_target;
    field[sio_pkg::IN_SETTLED_BIT] = position_settled;
    field[sio_pkg::IN_HOME_BIT] = home_position_flag;
    field[sio_pkg::IN_TORQ_LIMITED_BIT] = torque_limited_flag;
    field[sio_pkg::IN_SPD_LIMITED_BIT] = speed_limited_flag;
    field[sio_pkg::IN_SPD_MATCH_BIT] = speed_match_flag;
    field[sio_pkg::IN_GIN_LSB +: sio_pkg::GIN_W] = general_inputs;
  end

endmodule // sio_in_pack

/* sio_master_model.sv */
`timescale 1ns/1ps
module sio_master_model (
  input wire logic ref_clk,
  output logic cmd_sof,
  output logic cmd_byte_valid,
  output logic [7:0] cmd_byte,
  output logic cmd_eof,
  output logic rsp_req,
  output logic [7:0] rsp_index,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_valid
);
  // ****************************************************************
  // Frame and response requests
  // ****************************************************************
  initial {cmd_sof, cmd_byte_valid, cmd_byte, cmd_eof, rsp_req, rsp_index} = 20'h00000;
  task automatic send_frame(input logic [31:0] field, input int last, input bit tail);
    for (int i = 0; i <= last; i++) begin
      @(posedge ref_clk);
      cmd_sof <= (i == 0);
      cmd_byte_valid <= 1'b1;
      // field in bytes 8 to 11
      cmd_byte <= (i >= 8 && i <= 11) ? 8'(field >> (8 * (i & 3))) : 8'(i);
      cmd_eof <= (i == last) && !tail;
    end
    @(posedge ref_clk);
    cmd_sof <= 1'b0;
    cmd_byte_valid <= 1'b0;
    cmd_eof <= tail;
    // Idle lane shows the inverse so stale data never pass.
    cmd_byte <= ~cmd_byte;
    @(posedge ref_clk);
    cmd_eof <= 1'b0;
  endtask
  task automatic get_rsp(input logic [7:0] idx, output logic [7:0] d, output logic v);
    @(posedge ref_clk);
    rsp_req <= 1'b1;
    rsp_index <= idx;
    @(posedge ref_clk);
    rsp_req <= 1'b0;
    rsp_index <= ~idx;
    #1;
    d = rsp_data;
    v = rsp_valid;
  endtask
endmodule // sio_master_model

/* sio_pkg.sv */
package sio_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TORQ_W = 16;
  localparam int EV_W = 4;
  localparam int GOUT_W = 4;
  localparam int GIN_W = 8;

  // ****************************************************************
  // Frame positions of the I/O field
  // ****************************************************************
  localparam logic [7:0] IO_FIRST_BYTE = 8'h08;
  localparam logic [7:0] IO_LAST_BYTE = 8'h0B;

  // ****************************************************************
  // Command field bit positions
  // ****************************************************************
  localparam int CMD_FWD_CLAMP_BIT = 6;
  localparam int CMD_REV_CLAMP_BIT = 7;
  localparam int CMD_GOUT_LSB = 20;
  localparam logic [31:0] CMD_USED_MASK = 32'h00F000C0;

  // ****************************************************************
  // Response field bit positions
  // ****************************************************************
  localparam int IN_DECEL_BIT = 1;
  localparam int IN_FWD_OT_BIT = 2;
  localparam int IN_REV_OT_BIT = 3;
  localparam int IN_ESTOP_BIT = 7;
  localparam int IN_BRAKE_BIT = 9;
  localparam int IN_FWD_SOT_BIT = 10;
  localparam int IN_REV_SOT_BIT = 11;
  localparam int IN_PROFILE_DONE_BIT = 12;
  localparam int IN_CLOSE_BIT = 13;
  localparam int IN_SETTLED_BIT = 14;
  localparam int IN_HOME_BIT = 15;
  localparam int IN_TORQ_LIMITED_BIT = 16;
  localparam int IN_SPD_LIMITED_BIT = 17;
  localparam int IN_SPD_MATCH_BIT = 18;
  localparam int IN_GIN_LSB = 24;

  // ****************************************************************
  // Register offsets and reset values
  // ****************************************************************
  localparam logic [7:0] REG_FWD_CLAMP_PARAM = 8'h00;
  localparam logic [7:0] REG_REV_CLAMP_PARAM = 8'h04;
  localparam logic [7:0] REG_DRV_FWD_PARAM = 8'h08;
  localparam logic [7:0] REG_DRV_REV_PARAM = 8'h0C;
  localparam logic [7:0] REG_CMD_FIELD = 8'h10;
  localparam logic [7:0] REG_RSP_FIELD = 8'h14;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h18;
  localparam logic [7:0] REG_IRQ_CLEAR = 8'h1C;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h20;
  localparam logic [15:0] TORQ_NO_CLAMP = 16'hFFFF;
  localparam logic [15:0] TORQ_PARAM_RST = 16'hFFFF;
  localparam logic [3:0] IRQ_ENABLE_RST = 4'h0;

  // ****************************************************************
  // Interrupt event bits
  // ****************************************************************
  localparam int EV_FIELD_TAKEN = 0;
  localparam int EV_FWD_OT_DONE = 1;
  localparam int EV_REV_OT_DONE = 2;
  localparam int EV_ESTOP = 3;

  typedef enum logic [1:0] {
    SIO_IDLE = 2'b00,
    SIO_HEAD = 2'b01,
    SIO_FIELD = 2'b11,
    SIO_TAIL = 2'b10
  } sio_rx_state_t;

  function automatic logic [15:0] sio_min2(input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction

endpackage

/* sio_servo_io_fields.sv */
// Operation
// R1: Command frame bytes 8 to 11 carry the output field; outputs come from them.
// R2: A reported command alarm neither discards nor freezes either I/O field.
// R3: Forward clamp select set: forward torque is smallest of three limits.
// R4: Reverse clamp select set: reverse torque is smallest of three limits.
// R5: Command bits 20 to 23 drive the four general outputs on or off.
// R6: Response frame bytes 8 to 11 return the device's own signal states.
// R7: Input bit 1 reports the homing deceleration switch.
// R8: Input bit 2 is one while forward overtravel prohibits movement.
// R9: Input bit 3 is one while reverse overtravel prohibits movement.
// R10: Overtravel stop completion is judged from zero speed detection only.
// R11: Input bit 7 is one while either safe torque off channel trips.
// R12: Reserved bits are sent as zero and ignored on receipt.
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module sio_servo_io_fields (
  input wire logic ref_clk,
  input wire logic rst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // Command frame byte stream.
  input wire logic cmd_sof,
  input wire logic cmd_byte_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_eof,
  // Response frame byte requests.
  input wire logic rsp_req,
  input wire logic [7:0] rsp_index,
  output logic [7:0] rsp_data,
  output logic rsp_valid,
  // Drive side signals.
  input wire logic [15:0] commanded_torque_limit,
  input wire logic homing_decel_switch,
  input wire logic fwd_hw_overtravel,
  input wire logic rev_hw_overtravel,
  input wire logic safe_torque_off_a,
  input wire logic safe_torque_off_b,
  input wire logic zero_speed_detect,
  input wire logic holding_brake_applied,
  input wire logic fwd_sw_overtravel,
  input wire logic rev_sw_overtravel,
  input wire logic profile_output_done,
  input wire logic close_to_target,
  input wire logic position_settled,
  input wire logic home_position_flag,
  input wire logic torque_limited_flag,
  input wire logic speed_limited_flag,
  input wire logic speed_match_flag,
  input wire logic [7:0] general_inputs,
  // Decoded command outputs and stop status flags.
  output logic fwd_torque_clamp_sel,
  output logic rev_torque_clamp_sel,
  output logic [3:0] general_outputs,
  output logic [15:0] fwd_torque_clamp,
  output logic [15:0] rev_torque_clamp,
  output logic fwd_ot_stop_done,
  output logic rev_ot_stop_done,
  output logic emergency_stop_flag
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    sio_pkg::sio_rx_state_t rx_state;
    logic [7:0] byte_idx;
    logic [31:0] shadow;
    logic [31:0] out_field;
    logic [15:0] fwd_param;
    logic [15:0] rev_param;
    logic [15:0] drv_fwd;
    logic [15:0] drv_rev;
    logic [15:0] fwd_clamp;
    logic [15:0] rev_clamp;
    logic [31:0] in_field;
    logic estop;
    logic fwd_done;
    logic rev_done;
    logic [3:0] ev_stat;
    logic [3:0] ev_en;
    logic [31:0] rdata;
    logic [7:0] rsp_data;
    logic rsp_valid;
    logic irq;
  } sio_state_t;

  sio_state_t st_reg;
  sio_state_t st_next;

  logic [15:0] fwd_lim;
  logic [15:0] rev_lim;
  logic [31:0] in_field_now;
  logic estop_now;
  logic fwd_done_now;
  logic rev_done_now;
  logic [3:0] ev_pulse;
  logic [1:0] field_lane;

  // ****************************************************************
  // Torque clamp selection
  // ****************************************************************
  // R3: forward clamp minimum
  sio_clamp_min u_fwd_clamp (
    .sel(st_reg.out_field[sio_pkg::CMD_FWD_CLAMP_BIT]),
    .param_lim(st_reg.fwd_param),
    .cmd_lim(commanded_torque_limit),
    .drv_lim(st_reg.drv_fwd),
    .lim(fwd_lim)
  );

  // R4: reverse clamp minimum
  sio_clamp_min u_rev_clamp (
    .sel(st_reg.out_field[sio_pkg::CMD_REV_CLAMP_BIT]),
    .param_lim(st_reg.rev_param),
    .cmd_lim(commanded_torque_limit),
    .drv_lim(st_reg.drv_rev),
    .lim(rev_lim)
  );

  // ****************************************************************
  // Response field
  // ****************************************************************
  // R11: either channel trips stop
  assign estop_now = safe_torque_off_a | safe_torque_off_b;

  // R10: stop done from zero speed
  assign fwd_done_now = fwd_hw_overtravel & zero_speed_detect;
  assign rev_done_now = rev_hw_overtravel & zero_speed_detect;

  // R7: decel switch packed
  // R8: forward overtravel packed
  // R9: reverse overtravel packed
  sio_in_pack u_in_pack (
    .homing_decel_switch(homing_decel_switch),
    .fwd_hw_overtravel(fwd_hw_overtravel),
    .rev_hw_overtravel(rev_hw_overtravel),
    .emergency_stop_flag(estop_now),
    .holding_brake_applied(holding_brake_applied),
    .fwd_sw_overtravel(fwd_sw_overtravel),
    .rev_sw_overtravel(rev_sw_overtravel),
    .profile_output_done(profile_output_done),
    .close_to_target(close_to_target),
    .position_settled(position_settled),
    .home_position_flag(home_position_flag),
    .torque_limited_flag(torque_limited_flag),
    .speed_limited_flag(speed_limited_flag),
    .speed_match_flag(speed_match_flag),
    .general_inputs(general_inputs),
    .field(in_field_now)
  );

  // Byte offset within the I/O field, least significant byte first.
  assign field_lane = st_reg.byte_idx[1:0] - sio_pkg::IO_FIRST_BYTE[1:0];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    ev_pulse = 4'h0;

    // Command frame receiver.
    case (st_reg.rx_state)
      sio_pkg::SIO_IDLE: begin
        if (cmd_byte_valid && cmd_sof) begin
          st_next.byte_idx = 8'h01;
          st_next.rx_state = sio_pkg::SIO_HEAD;
        end
      end
      sio_pkg::SIO_HEAD: begin
        if (cmd_byte_valid) begin
          st_next.byte_idx = st_reg.byte_idx + 8'h01;
          if (st_reg.byte_idx == sio_pkg::IO_FIRST_BYTE) begin
            st_next.shadow[7:0] = cmd_byte;
            st_next.rx_state = sio_pkg::SIO_FIELD;
          end
        end
        if (cmd_eof) begin
          st_next.rx_state = sio_pkg::SIO_IDLE;
        end
      end
      sio_pkg::SIO_FIELD: begin
        // R1: take bytes 9 to 11; byte 8 is taken in SIO_HEAD
        if (cmd_byte_valid) begin
          st_next.byte_idx = st_reg.byte_idx + 8'h01;
          st_next.shadow[{field_lane, 3'b000} +: 8] = cmd_byte;
          if (st_reg.byte_idx == sio_pkg::IO_LAST_BYTE) begin
            st_next.rx_state = sio_pkg::SIO_TAIL;
          end
        end
        // A frame cut short inside the field leaves the old outputs alone.
        if (cmd_eof) begin
          if (st_next.rx_state == sio_pkg::SIO_TAIL) begin
            st_next.out_field = st_next.shadow & sio_pkg::CMD_USED_MASK;
            ev_pulse[sio_pkg::EV_FIELD_TAKEN] = 1'b1;
          end
          st_next.rx_state = sio_pkg::SIO_IDLE;
        end
      end
      sio_pkg::SIO_TAIL: begin
        if (cmd_byte_valid) begin
          st_next.byte_idx = st_reg.byte_idx + 8'h01;
        end
        if (cmd_eof) begin
          st_next.rx_state = sio_pkg::SIO_IDLE;
          // R2: no alarm gating applied
          // R12: reserved bits dropped
          st_next.out_field = st_reg.shadow & sio_pkg::CMD_USED_MASK;
          ev_pulse[sio_pkg::EV_FIELD_TAKEN] = 1'b1;
        end
      end
      default: begin
        st_next.rx_state = sio_pkg::SIO_IDLE;
      end
    endcase

    st_next.fwd_clamp = fwd_lim;
    st_next.rev_clamp = rev_lim;

    // R6: response field refreshed
    st_next.in_field = in_field_now;
    st_next.estop = estop_now;
    st_next.fwd_done = fwd_done_now;
    st_next.rev_done = rev_done_now;

    // Rising status edges raise interrupt events.
    ev_pulse[sio_pkg::EV_FWD_OT_DONE] = fwd_done_now & ~st_reg.fwd_done;
    ev_pulse[sio_pkg::EV_REV_OT_DONE] = rev_done_now & ~st_reg.rev_done;
    ev_pulse[sio_pkg::EV_ESTOP] = estop_now & ~st_reg.estop;

    // Response bytes outside the field read zero.
    st_next.rsp_valid = rsp_req;
    st_next.rsp_data = 8'h00;
    if (rsp_req && (rsp_index >= sio_pkg::IO_FIRST_BYTE) &&
        (rsp_index <= sio_pkg::IO_LAST_BYTE)) begin
      // R6: field bytes returned
      st_next.rsp_data = st_reg.in_field[{rsp_index[1:0], 3'b000} +: 8];
    end

    // Register writes.
    if (reg_wr) begin
      case (reg_addr)
        sio_pkg::REG_FWD_CLAMP_PARAM: begin
          st_next.fwd_param = reg_wdata[15:0];
        end
        sio_pkg::REG_REV_CLAMP_PARAM: begin
          st_next.rev_param = reg_wdata[15:0];
        end
        sio_pkg::REG_DRV_FWD_PARAM: begin
          st_next.drv_fwd = reg_wdata[15:0];
        end
        sio_pkg::REG_DRV_REV_PARAM: begin
          st_next.drv_rev = reg_wdata[15:0];
        end
        sio_pkg::REG_IRQ_ENABLE: begin
          st_next.ev_en = reg_wdata[3:0];
        end
        default: begin
        end
      endcase
    end

    // An event in the clearing cycle survives, so none is ever lost.
    if (reg_wr && (reg_addr == sio_pkg::REG_IRQ_CLEAR)) begin
      st_next.ev_stat = (st_reg.ev_stat & ~reg_wdata[3:0]) | ev_pulse;
    end else begin
      st_next.ev_stat = st_reg.ev_stat | ev_pulse;
    end
    st_next.irq = |(st_next.ev_stat & st_next.ev_en);

    // Register reads; data stand for one cycle only.
    st_next.rdata = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        sio_pkg::REG_FWD_CLAMP_PARAM: begin
          st_next.rdata[15:0] = st_reg.fwd_param;
        end
        sio_pkg::REG_REV_CLAMP_PARAM: begin
          st_next.rdata[15:0] = st_reg.rev_param;
        end
        sio_pkg::REG_DRV_FWD_PARAM: begin
          st_next.rdata[15:0] = st_reg.drv_fwd;
        end
        sio_pkg::REG_DRV_REV_PARAM: begin
          st_next.rdata[15:0] = st_reg.drv_rev;
        end
        sio_pkg::REG_CMD_FIELD: begin
          st_next.rdata = st_reg.out_field;
        end
        sio_pkg::REG_RSP_FIELD: begin
          st_next.rdata = st_reg.in_field;
        end
        sio_pkg::REG_IRQ_STATUS: begin
          st_next.rdata[3:0] = st_reg.ev_stat;
        end
        sio_pkg::REG_IRQ_ENABLE: begin
          st_next.rdata[3:0] = st_reg.ev_en;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg.rx_state <= sio_pkg::SIO_IDLE;
      st_reg.byte_idx <= 8'h00;
      st_reg.shadow <= 32'h00000000;
      st_reg.out_field <= 32'h00000000;
      st_reg.fwd_param <= sio_pkg::TORQ_PARAM_RST;
      st_reg.rev_param <= sio_pkg::TORQ_PARAM_RST;
      st_reg.drv_fwd <= sio_pkg::TORQ_PARAM_RST;
      st_reg.drv_rev <= sio_pkg::TORQ_PARAM_RST;
      st_reg.fwd_clamp <= sio_pkg::TORQ_NO_CLAMP;
      st_reg.rev_clamp <= sio_pkg::TORQ_NO_CLAMP;
      st_reg.in_field <= 32'h00000000;
      st_reg.estop <= 1'b0;
      st_reg.fwd_done <= 1'b0;
      st_reg.rev_done <= 1'b0;
      st_reg.ev_stat <= 4'h0;
      st_reg.ev_en <= sio_pkg::IRQ_ENABLE_RST;
      st_reg.rdata <= 32'h00000000;
      st_reg.rsp_data <= 8'h00;
      st_reg.rsp_valid <= 1'b0;
      st_reg.irq <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata = st_reg.rdata;
  assign irq = st_reg.irq;
  assign rsp_data = st_reg.rsp_data;
  assign rsp_valid = st_reg.rsp_valid;
  assign fwd_torque_clamp_sel = st_reg.out_field[sio_pkg::CMD_FWD_CLAMP_BIT];
  assign rev_torque_clamp_sel = st_reg.out_field[sio_pkg::CMD_REV_CLAMP_BIT];
  // R5: general outputs follow bits
  assign general_outputs = st_reg.out_field[sio_pkg::CMD_GOUT_LSB +: sio_pkg::GOUT_W];
  assign fwd_torque_clamp = st_reg.fwd_clamp;
  assign rev_torque_clamp = st_reg.rev_clamp;
  assign fwd_ot_stop_done = st_reg.fwd_done;
  assign rev_ot_stop_done = st_reg.rev_done;
  assign emergency_stop_flag = st_reg.estop;

endmodule // sio_servo_io_fields

/* sio_servo_io_fields_sva.sv */
`timescale 1ns/1ps
module sio_servo_io_fields_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic cmd_eof,
  input wire logic rsp_req,
  input wire logic [7:0] rsp_index,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_valid,
  input wire logic [15:0] commanded_torque_limit,
  input wire logic homing_decel_switch,
  input wire logic fwd_hw_overtravel,
  input wire logic rev_hw_overtravel,
  input wire logic safe_torque_off_a,
  input wire logic safe_torque_off_b,
  input wire logic zero_speed_detect,
  input wire logic fwd_torque_clamp_sel,
  input wire logic rev_torque_clamp_sel,
  input wire logic [3:0] general_outputs,
  input wire logic [15:0] fwd_torque_clamp,
  input wire logic [15:0] rev_torque_clamp,
  input wire logic fwd_ot_stop_done,
  input wire logic rev_ot_stop_done,
  input wire logic emergency_stop_flag
);
  // ****************************************************************
  // Port relations
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_estop_follows: assert property (
    !$past(rst) |-> emergency_stop_flag == $past(safe_torque_off_a | safe_torque_off_b))
    else $error("estop flag wrong");
  a_fwd_ot_done: assert property (
    !$past(rst) |-> fwd_ot_stop_done == $past(fwd_hw_overtravel & zero_speed_detect))
    else $error("fwd stop done wrong");
  a_rev_ot_done: assert property (
    !$past(rst) |-> rev_ot_stop_done == $past(rev_hw_overtravel & zero_speed_detect))
    else $error("rev stop done wrong");
  a_fwd_no_clamp: assert property (
    !fwd_torque_clamp_sel |=> fwd_torque_clamp == 16'hFFFF)
    else $error("fwd clamp without select");
  a_rev_no_clamp: assert property (
    !rev_torque_clamp_sel |=> rev_torque_clamp == 16'hFFFF)
    else $error("rev clamp without select");
  a_fwd_clamp_min: assert property (
    fwd_torque_clamp_sel ##1 $stable(commanded_torque_limit)
    |-> fwd_torque_clamp <= commanded_torque_limit)
    else $error("fwd clamp above limit");
  a_outputs_hold: assert property (
    !cmd_eof |=> $stable(general_outputs) && $stable(fwd_torque_clamp_sel))
    else $error("outputs moved off frame end");
  a_rsp_answer: assert property (
    rsp_req |=> rsp_valid)
    else $error("response missing");
  a_rsp_outside: assert property (
    rsp_req && (rsp_index < 8'h08 || rsp_index > 8'h0B) |=> rsp_data == 8'h00)
    else $error("outside byte not zero");
  a_rsp_low_bits: assert property (
    rsp_req && rsp_index == 8'h08 |=> rsp_data[3:1] ==
    $past({rev_hw_overtravel, fwd_hw_overtravel, homing_decel_switch}, 2))
    else $error("switch bits wrong");
  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 32'h0)
    else $error("stray read data");
endmodule // sio_servo_io_fields_sva

bind sio_servo_io_fields sio_servo_io_fields_sva sio_servo_io_fields_sva_i (.*);

/* sio_servo_io_fields_tb.sv */
`timescale 1ns/1ps
module sio_servo_io_fields_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] commanded_torque_limit = 16'h0300;
  logic [31:0] pat = 32'h0;
  logic [31:0] reg_rdata;
  logic [7:0] cmd_byte, rsp_index, rsp_data;
  logic irq, cmd_sof, cmd_byte_valid, cmd_eof, rsp_req, rsp_valid;
  logic fwd_torque_clamp_sel, rev_torque_clamp_sel, fwd_ot_stop_done, rev_ot_stop_done;
  logic emergency_stop_flag;
  logic [3:0] general_outputs;
  logic [15:0] fwd_torque_clamp, rev_torque_clamp;
  int num_errors = 0;
  int num_checks = 0;
  wire zero_speed_detect = pat[0];
  wire homing_decel_switch = pat[1];
  wire fwd_hw_overtravel = pat[2];
  wire rev_hw_overtravel = pat[3];
  wire safe_torque_off_a = pat[7] & pat[0];
  wire safe_torque_off_b = pat[7] & ~pat[0];
  wire holding_brake_applied = pat[9];
  wire fwd_sw_overtravel = pat[10];
  wire rev_sw_overtravel = pat[11];
  wire profile_output_done = pat[12];
  wire close_to_target = pat[13];
  wire position_settled = pat[14];
  wire home_position_flag = pat[15];
  wire torque_limited_flag = pat[16];
  wire speed_limited_flag = pat[17];
  wire speed_match_flag = pat[18];
  wire [7:0] general_inputs = pat[31:24];
  localparam logic [31:0] IN_MASK = 32'hFF07FE8E;

  sio_servo_io_fields sio_servo_io_fields_i (.*);
  sio_master_model sio_master_model_i (.*);

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_check(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    for (int a = 0; a < 16; a += 4) begin
      reg_check("param reset", 8'(a), 32'h0000FFFF);
    end
    reg_check("enable reset", sio_pkg::REG_IRQ_ENABLE, 32'h0);
    chk("outputs reset", 32'h0, general_outputs);
    chk("clamp reset", 32'hFFFFFFFF, {fwd_torque_clamp, rev_torque_clamp});
  endtask
  task automatic t_frame();
    sio_master_model_i.send_frame(32'hFFFFFFFF, 11, 1);
    wait_n(3);
    chk("clamp selects", 32'h3, {rev_torque_clamp_sel, fwd_torque_clamp_sel});
    chk("general outputs", 32'hF, general_outputs);
    reg_check("command field", sio_pkg::REG_CMD_FIELD, sio_pkg::CMD_USED_MASK);
    reg_write(sio_pkg::REG_FWD_CLAMP_PARAM, 32'h0100);
    reg_write(sio_pkg::REG_REV_CLAMP_PARAM, 32'h0500);
    reg_write(sio_pkg::REG_DRV_FWD_PARAM, 32'h0200);
    reg_write(sio_pkg::REG_DRV_REV_PARAM, 32'h0050);
    wait_n(3);
    chk("fwd clamp", 32'h0100, fwd_torque_clamp);
    chk("rev clamp", 32'h0050, rev_torque_clamp);
    @(posedge ref_clk);
    commanded_torque_limit <= 16'h0010;
    wait_n(3);
    chk("clamps by limit", 32'h00100010, {fwd_torque_clamp, rev_torque_clamp});
    sio_master_model_i.send_frame(32'h00500040, 11, 0);
    wait_n(3);
    chk("general outputs", 32'h5, general_outputs);
    chk("clamps one side", 32'h0010FFFF, {fwd_torque_clamp, rev_torque_clamp});
    // A cut frame leaves outputs alone.
    sio_master_model_i.send_frame(32'h00A00080, 10, 1);
    wait_n(3);
    chk("short frame", 32'h5, general_outputs);
  endtask
  task automatic t_inputs();
    logic [31:0] pats [3] = '{32'hFFFFFFFF, 32'h5A02A486, 32'h0};
    logic [7:0] d;
    logic v;
    foreach (pats[i]) begin
      @(posedge ref_clk);
      pat <= pats[i];
      wait_n(3);
      for (int b = 7; b < 13; b++) begin
        sio_master_model_i.get_rsp(8'(b), d, v);
        chk("response valid", 32'h1, v);
        chk("response byte", (b < 8 || b > 11) ? 32'h0 :
            ((pats[i] & IN_MASK) >> (8 * (b - 8))) & 32'hFF, d);
      end
      reg_check("response field", sio_pkg::REG_RSP_FIELD, pats[i] & IN_MASK);
      chk("estop", pats[i][7], emergency_stop_flag);
      chk("ot done", {pats[i][3] & pats[i][0], pats[i][2] & pats[i][0]},
          {rev_ot_stop_done, fwd_ot_stop_done});
    end
  endtask
  task automatic t_irq();
    reg_write(sio_pkg::REG_IRQ_CLEAR, 32'hF);
    reg_write(sio_pkg::REG_IRQ_ENABLE, 32'h1);
    wait_n(2);
    chk("irq idle", 32'h0, irq);
    sio_master_model_i.send_frame(32'h0, 11, 1);
    wait_n(3);
    reg_check("status taken", sio_pkg::REG_IRQ_STATUS, 32'h1);
    chk("irq raised", 32'h1, irq);
    reg_write(sio_pkg::REG_IRQ_ENABLE, 32'h8);
    wait_n(2);
    chk("irq masked", 32'h0, irq);
    @(posedge ref_clk);
    pat <= 32'h00000081;
    wait_n(3);
    chk("irq estop", 32'h1, irq);
    reg_check("status both", sio_pkg::REG_IRQ_STATUS, 32'h9);
    reg_write(sio_pkg::REG_IRQ_CLEAR, 32'hF);
    wait_n(2);
    chk("irq cleared", 32'h0, irq);
    reg_check("status cleared", sio_pkg::REG_IRQ_STATUS, 32'h0);
    reg_check("enable readback", sio_pkg::REG_IRQ_ENABLE, 32'h8);
    reg_check("unmapped", 8'h30, 32'h0);
    reg_write(sio_pkg::REG_CMD_FIELD, 32'hFFFFFFFF);
    reg_check("read only", sio_pkg::REG_CMD_FIELD, 32'h0);
  endtask

  always #10 ref_clk = ~ref_clk;
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_frame();
    t_inputs();
    t_irq();
    close_out();
  end
  initial begin
    #200000;
    num_errors++;
    close_out();
  end
endmodule // sio_servo_io_fields_tb
